//--- dv/ldt_ram_model.sv
/*
 display ram read port model.
 assumes the fetch handshake of ldt_timing; slow adds three wait cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module ldt_ram_model (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   // pacing
   input  wire logic         slow,
   // fetch port
   input  wire logic         ram_rd_req,
   input  wire logic [5:0]   ram_rd_line,
   input  wire logic         ram_rd_ready,
   output logic              ram_rd_valid,
   output logic [131:0]      ram_rd_data
);
   logic [1:0] wait_q;
   ////////////////////////////////////////
   // line content is the address repeated; idle bus flips every cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         ram_rd_valid <= 1'h0;
         wait_q       <= 2'h0;
         ram_rd_data  <= '0;
      end else if (ram_rd_valid) begin
         ram_rd_valid <= !ram_rd_ready;
         if (ram_rd_ready) ram_rd_data <= ~ram_rd_data;
      end else if (ram_rd_req && wait_q == (slow ? 2'h3 : 2'h0)) begin
         ram_rd_valid <= 1'h1;
         wait_q       <= 2'h0;
         ram_rd_data  <= {22{ram_rd_line}};
      end else begin
         wait_q      <= ram_rd_req ? wait_q + 2'h1 : 2'h0;
         ram_rd_data <= ~ram_rd_data;
      end
   end
endmodule : ldt_ram_model
`default_nettype wire

//--- dv/ldt_timing_monitor.sv
/*
 port checker of the display timing generator.
 assumes it is bound into ldt_timing and shares its line clock half period.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ldt_defines.svh"
module ldt_timing_monitor #(
   parameter int LINE_HALF = `LDT_LINE_HALF
) (
   // clock and reset
   input wire logic                       clk_sys,
   input wire logic                       rst_n,
   // commands
   input wire logic                       cmd_power_wr,
   input wire ldt_pkg::ldt_pwr_t          cmd_power,
   // pins
   input wire logic                       line_clock_o,
   input wire logic                       line_clock_oe,
   input wire logic                       frame_ac_toggle_o,
   input wire logic                       common_start_pulse_o,
   input wire logic                       common_start_pulse_oe,
   // fetch port
   input wire logic                       ram_rd_req,
   input wire logic [`LDT_START_W-1:0]    ram_rd_line,
   input wire logic                       ram_rd_valid,
   // drive outputs
   input wire logic                       osc_run,
   input wire ldt_pkg::ldt_pwr_t          power_circuit_enable,
   input wire logic                       contrast_enable,
   input wire logic [`LDT_CONTRAST_W-1:0] contrast_step
);
   import ldt_pkg::*;
   localparam int LP = 2 * LINE_HALF;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////
   AST_LCK_HALF: assert property ($rose(line_clock_o) |-> ##LINE_HALF $fell(line_clock_o))
      else $error("line clock half period wrong");
   AST_LINE_ADDR: assert property (line_clock_oe && $changed(ram_rd_line) |-> line_clock_o)
      else $error("line address moved off the line clock");
   AST_TOG_LCK: assert property (line_clock_oe && $changed(frame_ac_toggle_o) |-> line_clock_o)
      else $error("frame toggle moved off the line clock");
   AST_CSP_AT_TOG: assert property (line_clock_oe && $changed(frame_ac_toggle_o) |-> common_start_pulse_o)
      else $error("no common start pulse at toggle change");
   AST_CSP_END: assert property ($rose(common_start_pulse_o) |-> ##[1:LP] $changed(frame_ac_toggle_o))
      else $error("common start pulse without toggle change");
   AST_CSP_LEN: assert property ($rose(common_start_pulse_o) |-> common_start_pulse_o [*8])
      else $error("common start pulse too short");
   AST_ROLE: assert property (common_start_pulse_oe == line_clock_oe && osc_run == line_clock_oe)
      else $error("pin directions and oscillator disagree");
   AST_PWR_SLAVE: assert property (!osc_run |-> power_circuit_enable == 3'h0)
      else $error("power circuits on outside master mode");
   AST_PWR_LOAD: assert property (osc_run && cmd_power_wr |=> power_circuit_enable == $past(cmd_power))
      else $error("power setting not loaded");
   AST_CT_EN: assert property (contrast_enable == (contrast_step != 5'h00))
      else $error("contrast enable wrong");
   AST_REQ_HOLD: assert property (ram_rd_req && !ram_rd_valid |=> ram_rd_req && $stable(ram_rd_line))
      else $error("fetch request dropped or moved");
endmodule : ldt_timing_monitor

bind ldt_timing ldt_timing_monitor #(.LINE_HALF(LINE_HALF)) ldt_timing_monitor_i (.*);
`default_nettype wire

//--- dv/testbench.sv
/*
 self-checking bench of the display timing generator; its line fifo is reached through the top.
 assumes the ram model and the bound checker are compiled with it.
*/
`timescale 1ns/1ns
`default_nettype none
`include "ldt_defines.svh"
module testbench;
   import ldt_pkg::*;
   localparam int LH = 4;
   localparam int DU = 4;
   localparam logic [7:0] ROWS [7] = '{8'h49, 8'h5C, 8'hD9, 8'hCC, 8'h6C, 8'h19, 8'hB9};
   localparam logic [2:0] PWR [4] = '{3'h7, 3'h3, 3'h1, 3'h0};
   logic clk_sys = 1'h0, rst_n = 1'h0, cfg_master = 1'h1, slow = 1'h0, indicator_pixel = 1'h0;
   logic line_clock_i = 1'h0, frame_ac_toggle_i = 1'h0, display_off_sync_i = 1'h0;
   logic cmd_start_wr = 1'h0, cmd_power_wr = 1'h0, cmd_contrast_wr = 1'h0, cmd_disp_wr = 1'h0;
   logic [5:0] cmd_start_line = 6'h00;
   logic [4:0] cmd_contrast = 5'h00;
   ldt_pwr_t cmd_power = '0;
   ldt_disp_t cmd_disp = '0;
   logic line_clock_o, line_clock_oe, frame_ac_toggle_o, frame_ac_toggle_oe, display_off_sync_o;
   logic display_off_sync_oe, common_start_pulse_o, common_start_pulse_oe, osc_run, contrast_enable;
   logic ram_rd_req, ram_rd_valid, ram_rd_ready;
   logic [5:0] ram_rd_line, common_output;
   logic [131:0] ram_rd_data;
   logic [4:0] contrast_step;
   ldt_seg_t [132:0] segment_output;
   ldt_pwr_t power_circuit_enable;
   int num_errors = 0, checked = 0;
   logic lc_prev = 1'h0, tog_prev = 1'h0;
   logic [5:0] taken = 6'h00, shown = 6'h00;
   ////////////////////////////////////////
   always #20 clk_sys = ~clk_sys;
   ldt_timing #(.DUTY(DU), .LINE_HALF(LH)) ldt_timing_i (.*);
   ldt_ram_model ldt_ram_model_i (.*);
   // track which fetched line the latch should be showing
   always @(posedge clk_sys) begin
      if (ram_rd_valid && ram_rd_ready) taken = ram_rd_line;
      if (line_clock_o && !lc_prev) shown = taken;
      lc_prev = line_clock_o;
      tog_prev = frame_ac_toggle_o;
   end
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc
   task automatic chk(input logic [265:0] got, input logic [265:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : close_out
   task automatic do_reset(input logic m);
      rst_n = 1'h0;
      cfg_master = m;
      cyc(20);
      rst_n = 1'h1;
      cyc(8);
   endtask : do_reset
   task automatic pulse(ref logic s);
      s = 1'h1;
      cyc(1);
      s = 1'h0;
      cyc(1);
   endtask : pulse
   function automatic logic ev(input int w);
      case (w)
         0: return line_clock_o === 1'h1 && lc_prev === 1'h0;
         1: return frame_ac_toggle_o !== tog_prev;
         default: return ram_rd_valid === 1'h1 && ram_rd_ready === 1'h1;
      endcase
   endfunction : ev
   task automatic wait_ev(input int w);
      int k;
      k = 0;
      if (w < 2) cyc(1);
      while (!ev(w) && k < 200) begin
         cyc(1);
         k++;
      end
      if (k >= 200) num_errors++;
   endtask : wait_ev
   function automatic logic [1:0] code(input logic t, input logic blank, input logic pix);
      if (blank) return t ? 2'h1 : 2'h2;
      return t ? (pix ? 2'h0 : 2'h1) : (pix ? 2'h3 : 2'h2);
   endfunction : code
   task automatic look(input logic [7:0] r);
      logic [265:0] e;
      e = '0;
      for (int i = 0; i < 132; i++) begin
         e[2*i +: 2] = code(frame_ac_toggle_o, !r[6], r[5] | (shown[i % 6] ^ r[7]));
      end
      e[265:264] = frame_ac_toggle_o ? r[1:0] : r[3:2];
      chk(segment_output, e);
   endtask : look
   initial begin
      #200000;
      num_errors++;
      close_out();
   end
   initial begin
      logic [5:0] lnx;
      time t0;
      do_reset(1'h1);
      chk(266'({osc_run, line_clock_oe, frame_ac_toggle_oe, display_off_sync_oe, common_start_pulse_oe,
                power_circuit_enable}), 266'(8'hF8));
      chk(266'({contrast_enable, contrast_step}), 266'(6'h00));
      foreach (PWR[j]) begin
         cmd_power = PWR[j];
         pulse(cmd_power_wr);
         chk(266'(power_circuit_enable), 266'(PWR[j]));
      end
      cmd_contrast = 5'h1F;
      pulse(cmd_contrast_wr);
      chk(266'({contrast_enable, contrast_step}), 266'(6'h3F));
      cmd_contrast = 5'h00;
      pulse(cmd_contrast_wr);
      chk(266'(contrast_enable), 266'(1'h0));
      foreach (ROWS[j]) begin
         cmd_disp = ROWS[j][7:5];
         indicator_pixel = ROWS[j][4];
         pulse(cmd_disp_wr);
         wait_ev(0);
         wait_ev(0);
         cyc(2);
         look(ROWS[j]);
         cyc(3);
         look(ROWS[j]);
      end
      slow = 1'h1;
      wait_ev(1);
      cmd_start_line = 6'h3F;
      pulse(cmd_start_wr);
      wait_ev(1);
      t0 = $time;
      cyc(1);
      chk(266'(common_output), 266'(6'h00));
      lnx = 6'h3F;
      repeat (2) begin
         wait_ev(2);
         chk(266'(ram_rd_line), 266'(lnx));
         lnx++;
         cyc(1);
      end
      chk(266'(common_output), 266'(6'h01));
      wait_ev(1);
      chk(266'(($time - t0) / 40), 266'(2 * LH * DU));
      cmd_disp = 3'h2;
      indicator_pixel = 1'h0;
      lnx = 6'h3F;
      pulse(cmd_disp_wr);
      repeat (3) begin
         wait_ev(2);
         chk(266'(ram_rd_line), 266'(lnx));
         lnx++;
         cyc(1);
         chk(266'(ram_rd_req), 266'(1'h0));
         wait_ev(0);
         cyc(2);
         look(8'h49);
      end
      do_reset(1'h0);
      chk(266'({osc_run, line_clock_oe, frame_ac_toggle_oe, display_off_sync_oe, common_start_pulse_oe}),
          266'(5'h00));
      cmd_power = 3'h7;
      pulse(cmd_power_wr);
      chk(266'(power_circuit_enable), 266'(3'h0));
      cmd_disp = 3'h3;
      pulse(cmd_disp_wr);
      display_off_sync_i = 1'h1;
      repeat (3) begin
         line_clock_i = 1'h1;
         cyc(LH);
         line_clock_i = 1'h0;
         cyc(LH);
      end
      chk(266'(common_output), 266'(6'h03));
      chk(266'(segment_output[0]), 266'(2'h2));
      close_out();
   end
endmodule : testbench
`default_nettype wire

//--- hdl/ldt_timing.sv
/*
 display timing generator with its line data fifo.
 assumes one clock clk_sys (25 MHz), synchronous active-low rst_n, a display ram read port that answers
 fetches with valid/ready, and command strobes decoded elsewhere.
*/
// How it works
// - line clock advances counter and strobes latch
// - ram line address changes only on line clock
// - full 132-bit line latched each line clock
// - refresh fetch uses its own ram port
// - master frame toggle flips every frame
// - slave takes frame toggle and line clock in
// - master line clock divided from oscillator, driven out
// - common start pulse on trailing edge before toggle
// - common start driven only in master mode
// - master drives toggle, clock, off sync; slaves receive
// - latch holds line until the next line clock
// - display commands alter only latch outputs and the off sync pin
// - 133 segment outputs with four levels
// - level from pixel, scan state and toggle
// - oscillator runs in master mode only
// - power setting bits enable booster, regulator, follower
// - power circuits only available in master mode
// - oscillator kept running while booster enabled
// - contrast zero means contrast function off
// - frame toggle change preloads start line
// - contrast is 5 bits, cleared by reset
`timescale 1ns/1ns
`default_nettype none
`include "ldt_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module ldt_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // clock and reset
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   // fill side
   input  wire logic         in_valid,
   output logic             in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic             out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]     out_data
);
   localparam int AW = $clog2(D);
   if (D < 2 || (1 << AW) != D) begin : g_bad_depth
      $error("ldt_fifo depth must be a power of two, at least 2");
   end
   logic [W-1:0] mem [D];
   logic [AW:0]  wr_q;
   logic [AW:0]  rd_q;
   logic         push;
   logic         pop;
   assign in_ready  = (wr_q - rd_q) != (AW+1)'(D);
   assign out_valid = wr_q != rd_q;
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem[rd_q[AW-1:0]];
   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= in_data;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule : ldt_fifo

////////////////////////////////////////////////////////////////////////////////
module ldt_timing #(
   parameter int LINE_W    = `LDT_LINE_W,
   parameter int SEG_N     = `LDT_SEG_N,
   parameter int DUTY      = `LDT_DUTY,
   parameter int LINE_HALF = `LDT_LINE_HALF,
   parameter int FIFO_D    = `LDT_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic                               clk_sys,
   input  wire logic                               rst_n,
   // role strap
   input  wire logic                               cfg_master,
   // line clock pin
   input  wire logic                               line_clock_i,
   output logic                                    line_clock_o,
   output logic                                    line_clock_oe,
   // frame toggle pin
   input  wire logic                               frame_ac_toggle_i,
   output logic                                    frame_ac_toggle_o,
   output logic                                    frame_ac_toggle_oe,
   // display-off sync pin
   input  wire logic                               display_off_sync_i,
   output logic                                    display_off_sync_o,
   output logic                                    display_off_sync_oe,
   // common start pin
   output logic                                    common_start_pulse_o,
   output logic                                    common_start_pulse_oe,
   // commands
   input  wire logic                               cmd_start_wr,
   input  wire logic [`LDT_START_W-1:0]            cmd_start_line,
   input  wire logic                               cmd_power_wr,
   input  wire ldt_pkg::ldt_pwr_t                  cmd_power,
   input  wire logic                               cmd_contrast_wr,
   input  wire logic [`LDT_CONTRAST_W-1:0]         cmd_contrast,
   input  wire logic                               cmd_disp_wr,
   input  wire ldt_pkg::ldt_disp_t                 cmd_disp,
   input  wire logic                               indicator_pixel,
   // refresh read port
   output logic                                    ram_rd_req,
   output logic [`LDT_START_W-1:0]                 ram_rd_line,
   input  wire logic                               ram_rd_valid,
   output logic                                    ram_rd_ready,
   input  wire logic [LINE_W-1:0]                  ram_rd_data,
   // drive outputs
   output ldt_pkg::ldt_seg_t [SEG_N-1:0]           segment_output,
   output logic [`LDT_START_W-1:0]                 common_output,
   output logic                                    osc_run,
   output ldt_pkg::ldt_pwr_t                       power_circuit_enable,
   output logic                                    contrast_enable,
   output logic [`LDT_CONTRAST_W-1:0]              contrast_step
);
   import ldt_pkg::*;
   if (LINE_W != `LDT_LINE_W || SEG_N != LINE_W + 1) begin : g_bad_width
      $error("ldt_timing line and segment widths unsupported");
   end
   if (DUTY < 2 || DUTY > 64 || LINE_HALF < 1 || LINE_HALF > 65535) begin : g_bad_timing
      $error("ldt_timing timing out of range");
   end

   /////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and role capture
   logic [2:0] sync_cl_q;
   logic [2:0] sync_fr_q;
   logic [2:0] sync_dof_q;
   logic [2:0] sync_ms_q;
   logic       cl_lvl_q;
   logic       fr_lvl_q;
   logic       dof_lvl_q;
   logic       master_q;
   logic       role_ok_q;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         sync_cl_q  <= 3'h0;
         sync_fr_q  <= 3'h0;
         sync_dof_q <= 3'h0;
      end else begin
         sync_cl_q  <= {sync_cl_q[1:0], line_clock_i};
         sync_fr_q  <= {sync_fr_q[1:0], frame_ac_toggle_i};
         sync_dof_q <= {sync_dof_q[1:0], display_off_sync_i};
      end
   end
   // strap also shifts during reset, so its level is settled at release
   always_ff @(posedge clk_sys) begin
      sync_ms_q <= {sync_ms_q[1:0], cfg_master};
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cl_lvl_q  <= 1'b0;
         fr_lvl_q  <= 1'b0;
         dof_lvl_q <= 1'b0;
      end else begin
         if (sync_cl_q[1] == sync_cl_q[2]) cl_lvl_q <= sync_cl_q[2];
         if (sync_fr_q[1] == sync_fr_q[2]) fr_lvl_q <= sync_fr_q[2];
         if (sync_dof_q[1] == sync_dof_q[2]) dof_lvl_q <= sync_dof_q[2];
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         master_q  <= 1'b0;
         role_ok_q <= 1'b0;
      end else if (!role_ok_q && sync_ms_q[1] == sync_ms_q[2]) begin
         master_q  <= sync_ms_q[2];
         role_ok_q <= 1'b1;
      end
   end
   logic is_master;
   logic is_slave;
   assign is_master = role_ok_q & master_q;
   assign is_slave  = role_ok_q & ~master_q;

   /////////////////////////////////////////////////////////////////////////////
   // master line clock divider, phase and frame toggle
   localparam logic [15:0] HALF_M1 = 16'(LINE_HALF - 1);
   localparam logic [5:0]  DUTY_M1 = 6'(DUTY - 1);
   logic [15:0] div_q;
   logic        mcl_q;
   logic [5:0]  phase_q;
   logic        mfr_q;
   logic        mdyo_q;
   logic        div_tick;
   assign osc_run  = is_master;
   assign div_tick = osc_run && div_q == HALF_M1;
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !osc_run) begin
         div_q <= 16'h0000;
         mcl_q <= 1'b0;
      end else if (div_tick) begin
         div_q <= 16'h0000;
         mcl_q <= ~mcl_q;
      end else begin
         div_q <= div_q + 16'h0001;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !osc_run) begin
         phase_q <= 6'h00;
         mfr_q   <= 1'b0;
      end else if (div_tick && !mcl_q) begin
         if (phase_q == DUTY_M1) begin
            phase_q <= 6'h00;
            mfr_q   <= ~mfr_q;
         end else begin
            phase_q <= phase_q + 6'h01;
         end
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !osc_run) begin
         mdyo_q <= 1'b0;
      end else if (div_tick && mcl_q) begin
         mdyo_q <= phase_q == DUTY_M1;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // timing source select and events
   logic cl_now;
   logic fr_now;
   logic cl_prev_q;
   logic fr_prev_q;
   logic line_evt;
   logic fr_chg;
   assign cl_now = is_master ? mcl_q : cl_lvl_q;
   assign fr_now = is_master ? mfr_q : fr_lvl_q;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cl_prev_q <= 1'b0;
         fr_prev_q <= 1'b0;
      end else begin
         cl_prev_q <= cl_now;
         fr_prev_q <= fr_now;
      end
   end
   assign line_evt = role_ok_q & cl_now & ~cl_prev_q;
   assign fr_chg   = role_ok_q & (fr_now ^ fr_prev_q);

   /////////////////////////////////////////////////////////////////////////////
   // command registers
   logic [`LDT_START_W-1:0]    start_q;
   ldt_pwr_t                   pwr_q;
   logic [`LDT_CONTRAST_W-1:0] contrast_q;
   ldt_disp_t                  disp_q;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         start_q    <= `LDT_START_RST;
         pwr_q      <= ldt_pwr_t'(`LDT_PWR_RESET);
         contrast_q <= `LDT_CONTRAST_RST;
         disp_q     <= '0;
      end else begin
         if (cmd_start_wr) start_q <= cmd_start_line;
         if (cmd_power_wr) pwr_q <= cmd_power;
         if (cmd_contrast_wr) contrast_q <= cmd_contrast;
         if (cmd_disp_wr) disp_q <= cmd_disp;
      end
   end
   assign power_circuit_enable = is_master ? pwr_q : ldt_pwr_t'(`LDT_PWR_RESET);
   assign contrast_enable      = |contrast_q;
   assign contrast_step        = contrast_q;

   /////////////////////////////////////////////////////////////////////////////
   // line counter and refresh fetch
   logic [`LDT_START_W-1:0] line_q;
   logic [`LDT_START_W-1:0] com_q;
   ldt_fetch_t              fetch_q;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         line_q <= `LDT_START_RST;
         com_q  <= 6'h00;
      end else if (fr_chg) begin
         line_q <= start_q;
         com_q  <= 6'h00;
      end else if (line_evt) begin
         line_q <= line_q + 6'h01;
         com_q  <= com_q + 6'h01;
      end
   end
   assign ram_rd_line   = line_q;
   assign common_output = com_q;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         fetch_q <= LDT_F_IDLE;
      end else begin
         case (fetch_q)
            LDT_F_IDLE: begin
               if (line_evt || fr_chg) fetch_q <= LDT_F_WAIT;
            end
            LDT_F_WAIT: begin
               if (ram_rd_valid && ram_rd_ready) fetch_q <= LDT_F_IDLE;
            end
            default: fetch_q <= LDT_F_IDLE;
         endcase
      end
   end
   assign ram_rd_req = fetch_q == LDT_F_WAIT;

   /////////////////////////////////////////////////////////////////////////////
   // line buffer and display latch
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic [LINE_W-1:0] fifo_out_data;
   logic [LINE_W-1:0] latch_q;
   logic              ind_q;
   assign ram_rd_ready = ram_rd_req & fifo_in_ready;
   ldt_fifo #(.W(LINE_W), .D(FIFO_D)) u_fifo (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .in_valid  (ram_rd_valid & ram_rd_req),
      .in_ready  (fifo_in_ready),
      .in_data   (ram_rd_data),
      .out_valid (fifo_out_valid),
      .out_ready (line_evt),
      .out_data  (fifo_out_data)
   );
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         latch_q <= '0;
         ind_q   <= 1'b0;
      end else if (line_evt && fifo_out_valid) begin
         latch_q <= fifo_out_data;
         ind_q   <= indicator_pixel;
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // segment level select
   logic             blank;
   logic [SEG_N-1:0] pix_v;
   assign blank = is_master ? ~disp_q.display_on : dof_lvl_q;
   always_comb begin
      for (int i = 0; i < LINE_W; i++) begin
         pix_v[i] = disp_q.all_on | (latch_q[i] ^ disp_q.reverse);
      end
      pix_v[SEG_N-1] = disp_q.all_on | (ind_q ^ disp_q.reverse);
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         segment_output <= {SEG_N{LDT_SEG_V2}};
      end else begin
         for (int i = 0; i < SEG_N; i++) begin
            if (blank || !role_ok_q) begin
               segment_output[i] <= fr_now ? LDT_SEG_V2 : LDT_SEG_V3;
            end else begin
               segment_output[i] <= fr_now ? (pix_v[i] ? LDT_SEG_V0 : LDT_SEG_V2)
                                           : (pix_v[i] ? LDT_SEG_V5 : LDT_SEG_V3);
            end
         end
      end
   end

   /////////////////////////////////////////////////////////////////////////////
   // pin drive
   assign line_clock_o          = mcl_q;
   assign frame_ac_toggle_o     = mfr_q;
   assign display_off_sync_o    = ~disp_q.display_on;
   assign line_clock_oe         = is_master;
   assign frame_ac_toggle_oe    = is_master;
   assign display_off_sync_oe   = is_master;
   assign common_start_pulse_o  = mdyo_q;
   assign common_start_pulse_oe = is_master;
endmodule : ldt_timing
`default_nettype wire

//--- inc/ldt_defines.svh
/*
 constants of the display timing generator: widths, field positions, reset values, timing counts.
 assumes nothing; included by inc/ldt_pkg.sv, hdl/ldt_timing.sv and the dv monitor and testbench.
*/
`ifndef LDT_DEFINES_SVH
`define LDT_DEFINES_SVH
`define LDT_LINE_W        132
`define LDT_SEG_N         133
`define LDT_START_W       6
`define LDT_CONTRAST_W    5
`define LDT_PWR_W         3
`define LDT_PWR_BOOST_BIT 2
`define LDT_PWR_REG_BIT   1
`define LDT_PWR_FOLL_BIT  0
`define LDT_PWR_RESET     3'h0
`define LDT_CONTRAST_RST  5'h00
`define LDT_START_RST     6'h00
`define LDT_DUTY          33
`define LDT_LINE_HALF     16
`define LDT_FIFO_DEPTH    8
`endif

//--- inc/ldt_pkg.sv
/*
 types of the display timing generator.
 assumes ldt_defines.svh on the include path.
*/
`include "ldt_defines.svh"
package ldt_pkg;
   typedef enum logic [1:0] {
      LDT_SEG_V0,
      LDT_SEG_V2,
      LDT_SEG_V3,
      LDT_SEG_V5
   } ldt_seg_t;

   typedef struct packed {
      logic booster;
      logic regulator;
      logic follower;
   } ldt_pwr_t;

   typedef struct packed {
      logic reverse;
      logic display_on;
      logic all_on;
   } ldt_disp_t;

   typedef enum {
      LDT_F_IDLE,
      LDT_F_WAIT
   } ldt_fetch_t;
endpackage : ldt_pkg
